// ==== src/gpio_port_pkg.sv ====
// Package: offsets, reset values and state type of the eight-pin port block
package gpio_port_pkg;

	localparam int           PORT_WIDTH     = 8;
	localparam int           ADDR_WIDTH     = 12;

	// Byte offsets inside the port window
	localparam logic [11:0]  OFF_DATA       = 12'h000;
	localparam logic [11:0]  OFF_DIR        = 12'h400;
	localparam logic [11:0]  OFF_IS         = 12'h404;
	localparam logic [11:0]  OFF_IBE        = 12'h408;
	localparam logic [11:0]  OFF_IEV        = 12'h40C;
	localparam logic [11:0]  OFF_IM         = 12'h410;
	localparam logic [11:0]  OFF_RIS        = 12'h414;
	localparam logic [11:0]  OFF_MIS        = 12'h418;
	localparam logic [11:0]  OFF_ICR        = 12'h41C;
	localparam logic [11:0]  OFF_AFSEL      = 12'h420;
	localparam logic [11:0]  OFF_DR2R       = 12'h500;
	localparam logic [11:0]  OFF_DR4R       = 12'h504;
	localparam logic [11:0]  OFF_DR8R       = 12'h508;
	localparam logic [11:0]  OFF_ODR        = 12'h50C;
	localparam logic [11:0]  OFF_PUR        = 12'h510;
	localparam logic [11:0]  OFF_PDR        = 12'h514;
	localparam logic [11:0]  OFF_SLR        = 12'h518;
	localparam logic [11:0]  OFF_DEN        = 12'h51C;
	localparam logic [11:0]  OFF_ID_FIRST   = 12'hFD0;

	// Data window: upper two address bits zero, bits 9:2 form the mask
	localparam int           MASK_LSB       = 2;
	localparam int           MASK_MSB       = 9;

	// Reset values
	localparam logic [7:0]   RST_ZERO       = 8'h00;
	localparam logic [7:0]   RST_DR2R       = 8'hFF;
	localparam logic [7:0]   RST_PUR        = 8'hFF;
	localparam logic [7:0]   RST_DEN        = 8'hFF;
	localparam logic [7:0]   RST_AFSEL_B    = 8'h80;
	localparam logic [7:0]   RST_AFSEL_C    = 8'h0F;
	localparam logic [31:0]  RST_RDATA      = 32'h0000_0000;

	// Pin positions with special duties on port B
	localparam int           PIN_ADC_TRIG   = 4;
	localparam int           PIN_DBG_RESET  = 7;

	typedef struct packed {
		logic [7:0]  data;
		logic [7:0]  dir;
		logic [7:0]  is;
		logic [7:0]  ibe;
		logic [7:0]  iev;
		logic [7:0]  im;
		logic [7:0]  ris;
		logic [7:0]  afsel;
		logic [7:0]  dr2;
		logic [7:0]  dr4;
		logic [7:0]  dr8;
		logic [7:0]  odr;
		logic [7:0]  pur;
		logic [7:0]  pdr;
		logic [7:0]  slr;
		logic [7:0]  den;
		logic [7:0]  pin_out;
		logic [7:0]  pin_oe;
		logic [7:0]  alt_in;
		logic [31:0] rdata;
		logic        rvalid;
		logic        irq;
		logic        adc_trig;
		logic        dbg_rst_n;
	} port_state_t;

endpackage

// ==== src/pin_sync_edge.sv ====
// Two-stage pin synchroniser with rising and falling edge detection
`timescale 1ns/10ps
`default_nettype none

module pin_sync_edge #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	typedef struct packed {
		logic [WIDTH-1:0] sync1;
		logic [WIDTH-1:0] sync2;
		logic [WIDTH-1:0] prev;
		logic [2:0]       fill;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	always_comb begin
		next_st       = st;
		next_st.sync1 = pin_in;
		next_st.sync2 = st.sync1;
		next_st.prev  = st.sync2;
		next_st.fill  = {st.fill[1:0], 1'b1};
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		// Start at the pulled-up idle level so reset shows no false low
		if (!arst_n) begin
			st.sync1 <= '1;
			st.sync2 <= '1;
			st.prev  <= '1;
			st.fill  <= 3'h0;
		end else begin
			st <= next_st;
		end
	end

	// Edge is a change between the current and previous synced samples
	assign level = st.sync2;
	// No edges until the history holds three real pin samples
	assign rise  = st.sync2 & ~st.prev & {WIDTH{st.fill[2]}};
	assign fall  = ~st.sync2 & st.prev & {WIDTH{st.fill[2]}};

endmodule

`default_nettype wire

// ==== src/gpio_port_masked_irq.sv ====
// One eight-pin port: data, direction, interrupts, alternate function, pads
`timescale 1ns/10ps
`default_nettype none

module gpio_port_masked_irq #(
	parameter logic [7:0]  AFSEL_RESET = gpio_port_pkg::RST_ZERO,
	parameter logic [7:0]  PIN_MASK    = 8'hFF,
	parameter bit          IS_PORT_B   = 1'b0,
	// Identification bytes: values arbitrary
	parameter logic [95:0] ID_BYTES    = 96'h5A_A5_3C_C3_12_34_56_78_9A_BC_DE_F0
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        reg_req,
	input  wire logic        reg_write,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_rvalid,
	input  wire logic [7:0]  pin_in,
	output logic      [7:0]  pin_out,
	output logic      [7:0]  pin_oe,
	input  wire logic [7:0]  alt_out,
	input  wire logic [7:0]  alt_oe,
	output logic      [7:0]  alt_in,
	output logic      [7:0]  pad_drive_2ma,
	output logic      [7:0]  pad_drive_4ma,
	output logic      [7:0]  pad_drive_8ma,
	output logic      [7:0]  pad_pull_up,
	output logic      [7:0]  pad_pull_down,
	output logic      [7:0]  pad_slew,
	output logic      [7:0]  pad_digital_en,
	output logic             port_irq,
	output logic             adc_trigger,
	output logic             dbg_test_reset_n
);

	gpio_port_pkg::port_state_t st;
	gpio_port_pkg::port_state_t next_st;

	logic [7:0] lvl;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] edge_evt;
	logic [7:0] lvl_cond;
	logic [7:0] src_evt;
	logic [7:0] mask;
	logic [7:0] pin_view;
	logic [7:0] wbyte;
	logic       wr;
	logic       rd;
	logic       data_hit;

	pin_sync_edge #(
		.WIDTH  (gpio_port_pkg::PORT_WIDTH)
	) u_sync (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.pin_in  (pin_in),
		.level   (lvl),
		.rise    (rise),
		.fall    (fall)
	);

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a[11:2] == off[11:2]);
	endfunction

	// Identification byte for one of the twelve id words
	function automatic logic [7:0] id_byte(input logic [11:0] a);
		logic [3:0] idx;
		idx = a[5:2] - 4'h4;
		id_byte = 8'h00;
		if (idx < 4'hC) begin
			id_byte = ID_BYTES[8 * (11 - idx) +: 8];
		end
	endfunction

	assign wr       = reg_req & reg_write;
	assign rd       = reg_req & ~reg_write;
	assign data_hit = (reg_addr[11:10] == 2'b00);
	assign mask     = reg_addr[gpio_port_pkg::MASK_MSB:gpio_port_pkg::MASK_LSB];
	assign wbyte    = reg_wdata[7:0] & PIN_MASK;

	// Output pins show written data, input pins their synced level
	assign pin_view = (st.data & st.dir) | (lvl & ~st.dir);

	assign edge_evt = (st.ibe & (rise | fall))
		| (~st.ibe & st.iev & rise)
		| (~st.ibe & ~st.iev & fall);
	assign lvl_cond = ~(lvl ^ st.iev);
	assign src_evt  = (st.is & lvl_cond) | (~st.is & edge_evt);

	always_comb begin
		next_st        = st;
		next_st.rvalid = rd;
		next_st.rdata  = gpio_port_pkg::RST_RDATA;

		// Edge bits latch until cleared; level bits follow the level
		next_st.ris = (st.is & lvl_cond) | (~st.is & st.ris);
		if (wr && hit(reg_addr, gpio_port_pkg::OFF_ICR)) begin
			next_st.ris = next_st.ris & ~(wbyte & ~st.is);
		end
		next_st.ris = (next_st.ris | (~st.is & edge_evt)) & PIN_MASK;

		if (wr) begin
			if (data_hit) begin
				next_st.data = (st.data & ~mask) | (wbyte & mask);
			end else begin
				case (1'b1)
					hit(reg_addr, gpio_port_pkg::OFF_DIR):   next_st.dir   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_IS):    next_st.is    = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_IBE):   next_st.ibe   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_IEV):   next_st.iev   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_IM):    next_st.im    = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_AFSEL): next_st.afsel = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_DR2R):  next_st.dr2   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_DR4R):  next_st.dr4   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_DR8R):  next_st.dr8   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_ODR):   next_st.odr   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_PUR):   next_st.pur   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_PDR):   next_st.pdr   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_SLR):   next_st.slr   = wbyte;
					hit(reg_addr, gpio_port_pkg::OFF_DEN):   next_st.den   = wbyte;
					default: ;
				endcase
			end
		end

		// Input pins keep capturing their level into the data bits
		next_st.data = ((next_st.data & st.dir) | (lvl & ~st.dir)) & PIN_MASK;

		if (rd) begin
			if (data_hit) begin
				next_st.rdata = {24'h000000, pin_view & mask & PIN_MASK};
			end else if (reg_addr >= gpio_port_pkg::OFF_ID_FIRST) begin
				next_st.rdata = {24'h000000, id_byte(reg_addr)};
			end else begin
				case (1'b1)
					hit(reg_addr, gpio_port_pkg::OFF_DIR):   next_st.rdata[7:0] = st.dir;
					hit(reg_addr, gpio_port_pkg::OFF_IS):    next_st.rdata[7:0] = st.is;
					hit(reg_addr, gpio_port_pkg::OFF_IBE):   next_st.rdata[7:0] = st.ibe;
					hit(reg_addr, gpio_port_pkg::OFF_IEV):   next_st.rdata[7:0] = st.iev;
					hit(reg_addr, gpio_port_pkg::OFF_IM):    next_st.rdata[7:0] = st.im;
					hit(reg_addr, gpio_port_pkg::OFF_RIS):   next_st.rdata[7:0] = st.ris;
					hit(reg_addr, gpio_port_pkg::OFF_MIS):   next_st.rdata[7:0] = st.ris & st.im;
					hit(reg_addr, gpio_port_pkg::OFF_AFSEL): next_st.rdata[7:0] = st.afsel;
					hit(reg_addr, gpio_port_pkg::OFF_DR2R):  next_st.rdata[7:0] = st.dr2;
					hit(reg_addr, gpio_port_pkg::OFF_DR4R):  next_st.rdata[7:0] = st.dr4;
					hit(reg_addr, gpio_port_pkg::OFF_DR8R):  next_st.rdata[7:0] = st.dr8;
					hit(reg_addr, gpio_port_pkg::OFF_ODR):   next_st.rdata[7:0] = st.odr;
					hit(reg_addr, gpio_port_pkg::OFF_PUR):   next_st.rdata[7:0] = st.pur;
					hit(reg_addr, gpio_port_pkg::OFF_PDR):   next_st.rdata[7:0] = st.pdr;
					hit(reg_addr, gpio_port_pkg::OFF_SLR):   next_st.rdata[7:0] = st.slr;
					hit(reg_addr, gpio_port_pkg::OFF_DEN):   next_st.rdata[7:0] = st.den;
					default: ;
				endcase
			end
		end

		// Pin drive: peripheral when selected, else data and direction
		next_st.pin_out = (st.afsel & alt_out)
			| (~st.afsel & st.data);
		next_st.pin_oe  = ((st.afsel & alt_oe)
			| (~st.afsel & st.dir & ~(st.odr & st.data))) & PIN_MASK;
		next_st.alt_in  = lvl;

		next_st.irq = |(next_st.ris
			& next_st.im);
		next_st.adc_trig = IS_PORT_B
			& st.im[gpio_port_pkg::PIN_ADC_TRIG]
			& src_evt[gpio_port_pkg::PIN_ADC_TRIG];
		next_st.dbg_rst_n = ~(IS_PORT_B
			& st.afsel[gpio_port_pkg::PIN_DBG_RESET]
			& ~lvl[gpio_port_pkg::PIN_DBG_RESET]);
	end

	// Reset from power-on or external source arrives on arst_n
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st           <= '0;
			st.afsel     <= AFSEL_RESET & PIN_MASK;
			st.dr2       <= gpio_port_pkg::RST_DR2R & PIN_MASK;
			st.pur       <= gpio_port_pkg::RST_PUR & PIN_MASK;
			st.den       <= gpio_port_pkg::RST_DEN & PIN_MASK;
			st.dbg_rst_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata        = st.rdata;
	assign reg_rvalid       = st.rvalid;
	assign pin_out          = st.pin_out;
	assign pin_oe           = st.pin_oe;
	assign alt_in           = st.alt_in;
	assign pad_drive_2ma    = st.dr2;
	assign pad_drive_4ma    = st.dr4;
	assign pad_drive_8ma    = st.dr8;
	assign pad_pull_up      = st.pur;
	assign pad_pull_down    = st.pdr;
	assign pad_slew         = st.slr;
	assign pad_digital_en   = st.den;
	assign port_irq         = st.irq;
	assign adc_trigger      = st.adc_trig;
	assign dbg_test_reset_n = st.dbg_rst_n;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence data_write_s;
		wr && data_hit;
	endsequence

	sequence adc_event_s;
		IS_PORT_B && st.im[gpio_port_pkg::PIN_ADC_TRIG]
			&& src_evt[gpio_port_pkg::PIN_ADC_TRIG];
	endsequence

	masked_write_a: assert property (
		data_write_s |=> (((st.data ^ $past(st.data)) & ~$past(mask)
			& $past(st.dir)) == 8'h00))
		else $error("data bit changed outside write mask");

	masked_read_a: assert property (
		rd && data_hit |=> reg_rvalid
			&& ((reg_rdata & ~{24'h000000, $past(mask)}) == 32'h0))
		else $error("masked data bit read non-zero");

	output_drive_a: assert property (
		(st.afsel == 8'h00) && (st.odr == 8'h00) && $stable(st.dir)
			|=> pin_oe == ($past(st.dir) & PIN_MASK))
		else $error("pin enable does not follow direction");

	alt_handoff_a: assert property (
		1'b1 |=> (((pin_out ^ $past(alt_out)) & $past(st.afsel)) == 8'h00))
		else $error("alternate function not driving pin");

	single_irq_a: assert property (
		port_irq == |(st.ris & st.im))
		else $error("port interrupt not merge of masked status");

	edge_pending_a: assert property (
		!wr |=> ((($past(st.ris) & ~$past(st.is)) & ~st.ris) == 8'h00))
		else $error("pending edge interrupt lost without clear");

	clear_w1c_a: assert property (
		wr && hit(reg_addr, gpio_port_pkg::OFF_ICR) && !(|edge_evt)
			&& (st.is == 8'h00)
			|=> ((st.ris & $past(wbyte)) == 8'h00))
		else $error("clear write left interrupt pending");

	level_sense_a: assert property (
		$stable(st.is) && $stable(st.iev)
			|=> ((st.ris ^ $past(lvl_cond)) & $past(st.is)) == 8'h00)
		else $error("level status does not track pin level");

	adc_trigger_a: assert property (
		adc_event_s |=> adc_trigger)
		else $error("pin 4 event gave no ADC trigger");

	debug_reset_a: assert property (
		IS_PORT_B && st.afsel[gpio_port_pkg::PIN_DBG_RESET]
			&& !lvl[gpio_port_pkg::PIN_DBG_RESET] |=> !dbg_test_reset_n)
		else $error("low debug reset pin did not reset controller");

	reset_select_a: assert property (
		$rose(arst_n) |-> (st.afsel == (AFSEL_RESET & PIN_MASK))
			&& (st.dir == 8'h00) && (pin_oe == 8'h00))
		else $error("pins not inputs with reset select after reset");

	reset_default_a: assert property (
		$rose(arst_n) |-> (st.im == 8'h00) && (st.ris == 8'h00)
			&& (st.data == 8'h00) && !port_irq)
		else $error("port state not at defaults after reset");

	mask_block_a: assert property (
		(st.im == 8'h00) |-> !port_irq)
		else $error("masked pins still raise port interrupt");

	raw_status_a: assert property (
		rd && hit(reg_addr, gpio_port_pkg::OFF_RIS)
			|=> reg_rdata[7:0] == $past(st.ris))
		else $error("raw status read differs from pending bits");

	masked_status_a: assert property (
		rd && hit(reg_addr, gpio_port_pkg::OFF_MIS)
			|=> reg_rdata[7:0] == ($past(st.ris) & $past(st.im)))
		else $error("masked status read differs from passed bits");

	rise_detect_a: assert property (
		1'b1 |=> (($past(rise) & $past(st.iev) & ~$past(st.is)
			& ~$past(st.ibe) & PIN_MASK & ~st.ris) == 8'h00))
		else $error("rising edge did not set pending bit");

	fall_detect_a: assert property (
		1'b1 |=> (($past(fall) & ~$past(st.iev) & ~$past(st.is)
			& ~$past(st.ibe) & PIN_MASK & ~st.ris) == 8'h00))
		else $error("falling edge did not set pending bit");

	both_edges_a: assert property (
		1'b1 |=> ((($past(rise) | $past(fall)) & ~$past(st.is)
			& $past(st.ibe) & PIN_MASK & ~st.ris) == 8'h00))
		else $error("edge in both-edge mode did not set pending bit");

	zero_clear_a: assert property (
		wr && hit(reg_addr, gpio_port_pkg::OFF_ICR)
			|=> ((($past(st.ris) & ~$past(st.is) & ~$past(wbyte))
			& ~st.ris) == 8'h00))
		else $error("clear write with zero bit dropped a pending bit");

	open_drain_a: assert property (
		1'b1 |=> ((pin_oe & ~$past(st.afsel) & $past(st.odr)
			& $past(st.data)) == 8'h00))
		else $error("open-drain pin driven high");

endmodule

`default_nettype wire

// ==== sim/pad_model.sv ====
// Pad model: resolves each pin from port drive, outside drive and pulls
`timescale 1ns/10ps
`default_nettype none

module pad_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] pull_up,
	input  wire logic [7:0] pull_down,
	output logic      [7:0] pin_in
);
	logic [7:0] last;

	always_ff @(posedge clk_sys) begin
		last <= pin_in;
	end

	// A floating pin with no pull shows a moving value
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pull_up[i])
				pin_in[i] = 1'b1;
			else if (pull_down[i])
				pin_in[i] = 1'b0;
			else
				pin_in[i] = ~last[i];
		end
	end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Testbench for one port instance configured as port B
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic        clk_sys;
	logic        arst_n;
	logic        reg_req;
	logic        reg_write;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        reg_rvalid;
	logic [7:0]  pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in;
	logic [7:0]  pull_up, pull_down, ext_val, ext_en;
	logic        port_irq, adc_trigger, dbg_test_reset_n;
	int          num_errors = 0;
	int          n_tests = 0;
	// Identification bytes: values arbitrary
	localparam logic [95:0] ID_VAL = 96'h11_22_33_44_55_66_77_88_99_AA_BB_CC;

	gpio_port_masked_irq #(
		.AFSEL_RESET(gpio_port_pkg::RST_AFSEL_B),
		.IS_PORT_B  (1'b1),
		.ID_BYTES   (ID_VAL)
	) i_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req),
		.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out),
		.alt_oe(alt_oe), .alt_in(alt_in), .pad_drive_2ma(),
		.pad_drive_4ma(), .pad_drive_8ma(), .pad_pull_up(pull_up),
		.pad_pull_down(pull_down), .pad_slew(), .pad_digital_en(),
		.port_irq(port_irq), .adc_trigger(adc_trigger),
		.dbg_test_reset_n(dbg_test_reset_n)
	);

	pad_model i_pads (
		.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
		.ext_val(ext_val), .ext_en(ext_en), .pull_up(pull_up),
		.pull_down(pull_down), .pin_in(pin_in)
	);

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Request held over one rising edge, then one idle cycle
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_req = 1'b1;
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = {24'h000000, d};
		tick(1);
		reg_req = 1'b0;
		tick(1);
	endtask

	// Answer stands in the cycle after the request edge
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		reg_req = 1'b1;
		reg_write = 1'b0;
		reg_addr = a;
		tick(1);
		chk1(reg_rvalid, 1'b1);
		chk8(reg_rdata[7:0], exp);
		chk8(reg_rdata[31:24] | reg_rdata[23:16] | reg_rdata[15:8], 8'h00);
		reg_req = 1'b0;
		tick(1);
		chk1(reg_rvalid, 1'b0);
	endtask

	task automatic t_reset;
		rd(12'h400, 8'h00);
		rd(12'h420, 8'h80);
		rd(12'h500, 8'hFF);
		rd(12'h51C, 8'hFF);
		chk8(pull_up, 8'hFF);
		chk8(pin_oe, 8'h00);
		chk1(dbg_test_reset_n, 1'b1);
		ext_en = 8'h80;
		tick(6);
		chk1(dbg_test_reset_n, 1'b0);
		ext_en = 8'h00;
		tick(6);
		chk1(dbg_test_reset_n, 1'b1);
		$display("reset test done");
	endtask

	task automatic t_data;
		wr(12'h420, 8'h00);
		wr(12'h400, 8'hFF);
		wr(12'h3FC, 8'hFF);
		wr(12'h098, 8'hEB);
		tick(2);
		chk8(pin_out, 8'hFB);
		chk8(pin_oe, 8'hFF);
		rd(12'h3FC, 8'hFB);
		rd(12'h0C4, 8'h31);
		wr(12'h0C4, 8'h00);
		rd(12'h3FC, 8'hCA);
		wr(12'h50C, 8'h0F);
		tick(2);
		chk8(pin_oe, 8'hF5);
		wr(12'h50C, 8'h00);
		wr(12'h400, 8'h00);
		ext_val = 8'h5A;
		ext_en = 8'hFF;
		tick(6);
		chk8(pin_oe, 8'h00);
		rd(12'h3FC, 8'h5A);
		rd(12'h028, 8'h0A);
		ext_val = 8'h00;
		ext_en = 8'h14;
		$display("data test done");
	endtask

	task automatic t_edge;
		wr(12'h404, 8'h00);
		wr(12'h408, 8'h00);
		wr(12'h40C, 8'h04);
		wr(12'h41C, 8'hFF);
		wr(12'h410, 8'h04);
		tick(6);
		chk1(port_irq, 1'b0);
		ext_val[2] = 1'b1;
		tick(6);
		chk1(port_irq, 1'b1);
		rd(12'h418, 8'h04);
		ext_val[2] = 1'b0;
		tick(6);
		chk1(port_irq, 1'b1);
		wr(12'h41C, 8'h00);
		tick(2);
		chk1(port_irq, 1'b1);
		wr(12'h41C, 8'h04);
		tick(2);
		chk1(port_irq, 1'b0);
		wr(12'h410, 8'h00);
		wr(12'h408, 8'h04);
		wr(12'h40C, 8'h00);
		wr(12'h41C, 8'h04);
		wr(12'h410, 8'h04);
		ext_val[2] = 1'b1;
		tick(6);
		chk1(port_irq, 1'b1);
		wr(12'h41C, 8'h04);
		ext_val[2] = 1'b0;
		tick(6);
		chk1(port_irq, 1'b1);
		wr(12'h410, 8'h00);
		wr(12'h41C, 8'h04);
		ext_val[2] = 1'b1;
		tick(6);
		chk1(port_irq, 1'b0);
		rd(12'h414, 8'h04);
		rd(12'h418, 8'h00);
		$display("edge test done");
	endtask

	task automatic t_level;
		wr(12'h404, 8'h04);
		wr(12'h408, 8'h00);
		wr(12'h40C, 8'h00);
		wr(12'h410, 8'h04);
		tick(6);
		chk1(port_irq, 1'b0);
		ext_val[2] = 1'b0;
		tick(6);
		chk1(port_irq, 1'b1);
		wr(12'h41C, 8'h04);
		tick(2);
		chk1(port_irq, 1'b1);
		ext_val[2] = 1'b1;
		tick(6);
		chk1(port_irq, 1'b0);
		$display("level test done");
	endtask

	task automatic t_adc;
		logic seen;
		seen = 1'b0;
		wr(12'h410, 8'h00);
		wr(12'h404, 8'h00);
		wr(12'h40C, 8'h10);
		wr(12'h41C, 8'hFF);
		wr(12'h410, 8'h10);
		ext_val[4] = 1'b1;
		for (int i = 0; i < 8; i++) begin
			tick(1);
			seen |= adc_trigger;
		end
		chk1(seen, 1'b1);
		chk1(port_irq, 1'b1);
		$display("trigger test done");
	endtask

	task automatic t_alt;
		wr(12'h410, 8'h00);
		wr(12'h420, 8'h01);
		alt_oe = 8'h01;
		alt_out = 8'h01;
		tick(2);
		chk8(pin_oe, 8'h01);
		chk1(pin_out[0], 1'b1);
		alt_out = 8'h00;
		tick(2);
		chk1(pin_out[0], 1'b0);
		tick(4);
		chk1(alt_in[4], 1'b1);
		$display("alternate test done");
	endtask

	task automatic t_rerun;
		wr(12'h400, 8'hF0);
		arst_n = 1'b0;
		tick(2);
		arst_n = 1'b1;
		tick(3);
		rd(12'h400, 8'h00);
		rd(12'h420, 8'h80);
		rd(12'h410, 8'h00);
		chk1(port_irq, 1'b0);
		rd(12'h600, 8'h00);
		rd(12'hFD0, ID_VAL[95:88]);
		wr(12'hFE0, 8'h00);
		rd(12'hFE0, ID_VAL[63:56]);
		rd(12'hFFC, ID_VAL[7:0]);
		$display("second reset test done");
	endtask

	initial begin
		#(40 * 20000);
		num_errors++;
		complete_run();
	end

	initial begin
		arst_n = 1'b0;
		reg_req = 1'b0;
		reg_write = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 32'h00000000;
		alt_out = 8'h00;
		alt_oe = 8'h00;
		ext_val = 8'h00;
		ext_en = 8'h00;
		tick(10);
		arst_n = 1'b1;
		tick(3);
		t_reset();
		t_data();
		t_edge();
		t_level();
		t_adc();
		t_alt();
		t_rerun();
		complete_run();
	end
endmodule
`default_nettype wire
